/* File: pkg/ebt_pkg.sv */
// shared constants, types and field decoders for the bus spacing shaper
package ebt_pkg;

  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] EBT_CFG_OFF = 4'h0;
  localparam logic [3:0] EBT_STAT_OFF = 4'h4;
  localparam logic [15:0] EBT_CFG_RST = 16'hffff;

  // field positions inside the spacing configuration
  localparam int EBT_GAP_LSB = 8;
  localparam int EBT_CW_LSB = 4;
  localparam int EBT_SW_LSB = 0;

  // ---------------------------------------------------------------
  // counts and idle pin levels
  // ---------------------------------------------------------------
  localparam logic [1:0] EBT_QUIET_MAX = 2'h3;
  localparam logic [1:0] EBT_QUIET_ONE = 2'h1;
  localparam logic EBT_STB_LAST = 1'h1; // strobe phase lasts two cycles
  localparam logic [3:0] EBT_SEL_IDLE = 4'hf;
  localparam logic [1:0] EBT_WR_IDLE = 2'h3;

  typedef enum logic [1:0] {EBT_IDLE, EBT_SETUP, EBT_STROBE, EBT_HOLD} ebt_state_t;

  // ---------------------------------------------------------------
  // field decoders
  // ---------------------------------------------------------------
  function automatic logic [1:0] ebt_gap_field(input logic [15:0] cfg, input logic [1:0] sp);
    ebt_gap_field = cfg[EBT_GAP_LSB + 2 * sp +: 2];
  endfunction : ebt_gap_field

  function automatic logic ebt_cw_bit(input logic [15:0] cfg, input logic [1:0] sp);
    ebt_cw_bit = cfg[EBT_CW_LSB + sp];
  endfunction : ebt_cw_bit

  function automatic logic ebt_sw_bit(input logic [15:0] cfg, input logic [1:0] sp);
    ebt_sw_bit = cfg[EBT_SW_LSB + sp];
  endfunction : ebt_sw_bit

  function automatic logic [1:0] ebt_max2(input logic [1:0] a, input logic [1:0] b);
    ebt_max2 = (a > b) ? a : b;
  endfunction : ebt_max2

endpackage : ebt_pkg

/* File: pkg/ebt_cfg_if.sv */
// configuration and status carrier between register file and sequencer
`timescale 1ns/1ps
interface ebt_cfg_if;
  logic [15:0] cfg;
  logic [7:0] status;
  modport regs (output cfg, input status);
  modport seq (input cfg, output status);
endinterface : ebt_cfg_if

/* File: verilog/ebt_regs.sv */
// wishbone slave holding the spacing configuration and the status word
`timescale 1ns/1ps
module ebt_regs
  import ebt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic hw_standby,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  ebt_cfg_if.regs cfg_if
);

  typedef struct packed {
    logic [15:0] cfg;
    logic ack;
    logic [31:0] dat;
  } ebt_regs_state_t;

  ebt_regs_state_t r_reg;
  ebt_regs_state_t r_next;

  // ---------------------------------------------------------------
  // decode and write
  // ---------------------------------------------------------------
  // one-cycle answer; ack drops after one cycle so a held stb is not seen twice
  always_comb begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      r_next.ack = 1'b1;
      r_next.dat = 32'h0; // unmapped offsets read as zero
      if (wb_adr_i == EBT_CFG_OFF) begin
        r_next.dat = {16'h0, r_reg.cfg};
        if (wb_we_i && wb_sel_i[0]) r_next.cfg[7:0] = wb_dat_i[7:0];
        if (wb_we_i && wb_sel_i[1]) r_next.cfg[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == EBT_STAT_OFF) begin
        r_next.dat = {24'h0, cfg_if.status};
      end
    end
    // hardware standby wins over a write in the same cycle
    if (hw_standby) r_next.cfg = EBT_CFG_RST;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r_reg <= '{cfg: EBT_CFG_RST, ack: 1'b0, dat: 32'h0};
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.dat;
  assign cfg_if.cfg = r_reg.cfg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  cfg_reset_a: assert property (@(posedge ref_clk)
    (srst || (hw_standby && clk_en)) |=> r_reg.cfg == EBT_CFG_RST)
    else $error("config not all ones after reset or standby");
  ack_pulse_a: assert property (@(posedge ref_clk) disable iff (srst)
    (r_reg.ack && clk_en) |=> !r_reg.ack)
    else $error("bus ack held longer than one cycle");

endmodule : ebt_regs

/* File: verilog/ebt_gap_calc.sv */
// idle count needed before the next access, and its stretch setting
`timescale 1ns/1ps
module ebt_gap_calc
  import ebt_pkg::*;
(
  input wire logic [15:0] cfg,
  input wire logic prev_valid,
  input wire logic prev_read,
  input wire logic [1:0] prev_space,
  input wire logic [1:0] next_space,
  input wire logic next_we,
  output logic [1:0] gap,
  output logic stretch
);

  logic same;
  logic [1:0] iw;
  logic [1:0] cw;

  // gap follows the space just left, never the one being entered
  always_comb begin
    same = (prev_space == next_space);
    iw = 2'h0;
    cw = 2'h0;
    if (prev_valid && prev_read && (!same || next_we)) begin
      iw = ebt_gap_field(cfg, prev_space);
    end
    if (prev_valid && same) begin
      cw = {1'b0, ebt_cw_bit(cfg, prev_space)};
    end
    gap = ebt_max2(iw, cw);
    stretch = ebt_sw_bit(cfg, next_space);
  end

endmodule : ebt_gap_calc

/* File: verilog/ebt_spacing.sv */
// external bus spacing shaper: idle insertion and select stretching
`timescale 1ns/1ps

// Overview of operation
// - 16-bit spacing config, read/write, loads all ones on reset or hardware standby
// - software standby leaves the spacing config untouched
// - after a read, a change of space waits the programmed idle cycles
// - read then write waits idle cycles even in the same space
// - idle count comes from the space of the preceding access
// - two-bit idle field per space at bits 15-8, space 3 highest
// - field 00..11 gives zero to three idle cycles; resets to three
// - back-to-back bit set: select negated one cycle between same-space accesses
// - back-to-back bits at 7-4, space 3 highest, reset to one
// - write after read waits the larger of the two idle counts
// - stretch bit set: one select cycle added before and after the bus cycle
// - strobes only ever asserted while the space select is asserted
// - stretch bits at 3-0, space 3 highest, reset to one, zero disables
module ebt_spacing
  import ebt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [1:0] acc_space,
  input wire logic [1:0] acc_be,
  input wire logic [15:0] acc_wdata,
  output logic acc_ack,
  output logic acc_rvalid,
  output logic [15:0] acc_rdata,
  input wire logic [15:0] mem_rdata,
  output logic [3:0] space_select_n,
  output logic read_strobe_n,
  output logic [1:0] write_strobe_n,
  output logic [15:0] mem_wdata,
  output logic mem_wdata_oe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    ebt_state_t st;
    logic cnt;
    logic [1:0] quiet;
    logic [1:0] req_space;
    logic req_we;
    logic [1:0] req_be;
    logic [15:0] req_wdata;
    logic prev_valid;
    logic prev_read;
    logic [1:0] prev_space;
    logic [3:0] sel_n;
    logic rd_n;
    logic [1:0] wr_n;
    logic wd_oe;
    logic ack;
    logic rvalid;
    logic [15:0] rdata;
  } ebt_seq_state_t;

  ebt_seq_state_t r_reg;
  ebt_seq_state_t r_next;

  ebt_cfg_if cfg_if ();

  logic in_acc;
  logic g_prev_valid;
  logic g_prev_read;
  logic [1:0] g_prev_space;
  logic [1:0] gap;
  logic stretch_next;
  logic stretch_cur;
  logic req_ok;

  // ---------------------------------------------------------------
  // register file and gap decoder
  // ---------------------------------------------------------------
  ebt_regs u_regs (
    .ref_clk(ref_clk),
    .srst(srst),
    .clk_en(clk_en),
    .hw_standby(hw_standby),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .cfg_if(cfg_if.regs)
  );

  // while an access runs it is the one the next access follows
  assign in_acc = (r_reg.st != EBT_IDLE);
  assign g_prev_valid = in_acc || r_reg.prev_valid;
  assign g_prev_read = in_acc ? !r_reg.req_we : r_reg.prev_read;
  assign g_prev_space = in_acc ? r_reg.req_space : r_reg.prev_space;

  ebt_gap_calc u_gap (
    .cfg(cfg_if.cfg),
    .prev_valid(g_prev_valid),
    .prev_read(g_prev_read),
    .prev_space(g_prev_space),
    .next_space(acc_space),
    .next_we(acc_we),
    .gap(gap),
    .stretch(stretch_next)
  );

  assign stretch_cur = ebt_sw_bit(cfg_if.cfg, r_reg.req_space);

  // masked in the cycle of our own ack, the request is still the old one
  assign req_ok = acc_req && !r_reg.ack && !sw_standby;

  // status: busy, last space, last was read, last valid, idle count
  assign cfg_if.status = {1'b0, r_reg.quiet, r_reg.prev_valid, r_reg.prev_read,
                          r_reg.prev_space, in_acc};

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    logic start;
    logic finish;
    logic act;
    start = 1'b0;
    finish = 1'b0;
    act = 1'b0;
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.rvalid = 1'b0;
    unique case (r_reg.st)
      EBT_IDLE: begin
        // wait here until enough quiet cycles have gone by
        if (req_ok && r_reg.quiet >= gap) begin
          start = 1'b1;
        end else if (r_reg.quiet != EBT_QUIET_MAX) begin
          r_next.quiet = r_reg.quiet + 2'h1;
        end
      end
      EBT_SETUP: begin
        r_next.st = EBT_STROBE;
      end
      EBT_STROBE: begin
        r_next.cnt = ~r_reg.cnt;
        if (r_reg.cnt == EBT_STB_LAST) begin
          r_next.rvalid = !r_reg.req_we;
          if (!r_reg.req_we) r_next.rdata = mem_rdata;
          if (stretch_cur) r_next.st = EBT_HOLD;
          else finish = 1'b1;
        end
      end
      EBT_HOLD: begin
        finish = 1'b1;
      end
    endcase
    if (finish) begin
      r_next.st = EBT_IDLE;
      r_next.prev_valid = 1'b1;
      r_next.prev_read = !r_reg.req_we;
      r_next.prev_space = r_reg.req_space;
      r_next.quiet = EBT_QUIET_ONE;
      // only a zero gap lets the next access follow with no break
      if (req_ok && gap == 2'h0) start = 1'b1;
    end
    if (start) begin
      r_next.req_space = acc_space;
      r_next.req_we = acc_we;
      r_next.req_be = acc_be;
      r_next.req_wdata = acc_wdata;
      r_next.cnt = 1'b0;
      r_next.ack = 1'b1;
      r_next.st = stretch_next ? EBT_SETUP : EBT_STROBE;
    end
    // pins follow the next state so they leave flip-flops directly
    act = (r_next.st != EBT_IDLE);
    r_next.sel_n = act ? ~(4'h1 << r_next.req_space) : EBT_SEL_IDLE;
    r_next.rd_n = !(r_next.st == EBT_STROBE && !r_next.req_we);
    r_next.wr_n = (r_next.st == EBT_STROBE && r_next.req_we) ? ~r_next.req_be
                  : EBT_WR_IDLE;
    // data driven across setup, strobe and hold of a write
    r_next.wd_oe = act && r_next.req_we;
  end

  // config lives in the register file, whose only standby path is hardware standby
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r_reg <= '{st: EBT_IDLE, quiet: EBT_QUIET_MAX, sel_n: EBT_SEL_IDLE, rd_n: 1'b1,
                 wr_n: EBT_WR_IDLE, default: '0};
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign acc_ack = r_reg.ack;
  assign acc_rvalid = r_reg.rvalid;
  assign acc_rdata = r_reg.rdata;
  assign space_select_n = r_reg.sel_n;
  assign read_strobe_n = r_reg.rd_n;
  assign write_strobe_n = r_reg.wr_n;
  assign mem_wdata = r_reg.req_wdata;
  assign mem_wdata_oe = r_reg.wd_oe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // helper: quiet cycles seen on the pins before a select goes low
  logic sel_any;
  logic sel_q;
  logic sel_start;
  logic same_sp;
  logic [2:0] quiet_h;

  assign sel_any = (r_reg.sel_n != EBT_SEL_IDLE);
  assign sel_start = sel_any && !sel_q;
  assign same_sp = (r_reg.req_space == r_reg.prev_space);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sel_q <= 1'b0;
      quiet_h <= 3'h7;
    end else if (clk_en) begin
      sel_q <= sel_any;
      if (sel_any) quiet_h <= 3'h0;
      else if (quiet_h != 3'h7) quiet_h <= quiet_h + 3'h1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst || !clk_en);

  idle_quiet_a: assert property (
    (r_reg.st == EBT_IDLE) |-> (!sel_any && r_reg.rd_n && r_reg.wr_n == EBT_WR_IDLE))
    else $error("pins active during idle cycles");

  strobe_in_select_a: assert property (
    (!r_reg.rd_n || r_reg.wr_n != EBT_WR_IDLE) |-> (sel_any && r_reg.st == EBT_STROBE))
    else $error("strobe outside select");

  stretch_lead_a: assert property (
    (sel_start && stretch_cur) |-> (r_reg.rd_n && r_reg.wr_n == EBT_WR_IDLE)
      ##1 (!r_reg.rd_n || r_reg.wr_n != EBT_WR_IDLE))
    else $error("missing lead select cycle");

  stretch_off_a: assert property (
    (sel_start && !stretch_cur) |-> (!r_reg.rd_n || r_reg.wr_n != EBT_WR_IDLE))
    else $error("lead cycle added with stretch cleared");

  wdata_hold_a: assert property (
    (r_reg.st == EBT_STROBE && r_reg.cnt == EBT_STB_LAST && stretch_cur && r_reg.req_we)
      |=> (sel_any && r_reg.wr_n == EBT_WR_IDLE && r_reg.wd_oe) ##1 (!sel_any || r_reg.ack))
    else $error("write data not held in tail cycle");

  gap_other_a: assert property (
    (sel_start && r_reg.prev_valid && r_reg.prev_read && !same_sp)
      |-> quiet_h >= {1'b0, ebt_gap_field(cfg_if.cfg, r_reg.prev_space)})
    else $error("too few idles after read on space change");

  gap_rd_wr_a: assert property (
    (sel_start && r_reg.prev_valid && r_reg.prev_read && r_reg.req_we && same_sp)
      |-> quiet_h >= {1'b0, ebt_max2(ebt_gap_field(cfg_if.cfg, r_reg.prev_space),
                                      {1'b0, ebt_cw_bit(cfg_if.cfg, r_reg.prev_space)})})
    else $error("too few idles for write after read");

  back_to_back_a: assert property (
    (sel_start && r_reg.prev_valid && same_sp && ebt_cw_bit(cfg_if.cfg, r_reg.prev_space))
      |-> quiet_h >= 3'h1)
    else $error("no select break between same-space accesses");

  start_on_expiry_a: assert property (
    (r_reg.st == EBT_IDLE && req_ok && r_reg.quiet >= gap) |=> (sel_any && r_reg.ack))
    else $error("access not started after idle expired");

  cfg_keep_a: assert property (
    (sw_standby && !(wb_cyc_i && wb_stb_i) && !hw_standby) |=> $stable(cfg_if.cfg))
    else $error("config changed in software standby");

  rd_wr_cov_c: cover property (sel_start && r_reg.prev_read && r_reg.req_we && same_sp);
  stretch_wr_cov_c: cover property (sel_start && stretch_cur && r_reg.req_we);
  gap_three_cov_c: cover property (sel_start && r_reg.prev_valid && quiet_h == 3'h3);
  // zero gap: next access follows with its select never released
  chain_cov_c: cover property (r_reg.ack && sel_q && sel_any);

  wdata_oe_a: assert property (
    (sel_any && r_reg.req_we) |-> r_reg.wd_oe)
    else $error("write data not driven during write select");

endmodule : ebt_spacing

/* File: verif/ebt_mem_model.sv */
// behavioural memory standing on the four select spaces
`timescale 1ns/1ps
module ebt_mem_model (
  input wire logic ref_clk,
  input wire logic [3:0] space_select_n,
  input wire logic read_strobe_n,
  input wire logic [1:0] write_strobe_n,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [15:0] word_reg [4];
  int sp;
  // ------------------------------------------------------------
  // storage and read path
  // ------------------------------------------------------------
  // one word per space; data toggles when not read, so a late sample shows
  always @(posedge ref_clk) begin
    sp = 0;
    for (int i = 0; i < 4; i++) begin
      if (space_select_n[i] === 1'b0) sp = i;
    end
    if (write_strobe_n[0] === 1'b0) word_reg[sp][7:0] <= mem_wdata[7:0];
    if (write_strobe_n[1] === 1'b0) word_reg[sp][15:8] <= mem_wdata[15:8];
    mem_rdata <= (read_strobe_n === 1'b0) ? word_reg[sp] : ~mem_rdata;
  end
  initial begin
    mem_rdata = 16'h0;
    word_reg = '{default: 16'h0};
  end
endmodule : ebt_mem_model

/* File: verif/tb_top.sv */
// self-checking bench for the bus spacing shaper
`timescale 1ns/1ps
module tb_top;
  import ebt_pkg::*;
  logic ref_clk, srst, clk_en, hw_standby, sw_standby, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0] wb_adr_i, wb_sel_i, space_select_n;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic wb_ack_o, acc_req, acc_we, acc_ack, acc_rvalid, read_strobe_n, mem_wdata_oe;
  logic [1:0] acc_space, acc_be, write_strobe_n, cur_be, ps, cur_sp;
  logic [15:0] acc_wdata, acc_rdata, mem_rdata, mem_wdata, cfg_sh, v;
  logic [15:0] word_sh [4];
  logic [15:0] rq [$];
  logic stb_now, stb_prev, cont, pw, cur_sw, cur_we;
  int bad_count = 0, tests_run = 0, quiet;

  ebt_spacing dut_u (.ref_clk, .srst, .clk_en, .hw_standby, .sw_standby, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .acc_req,
    .acc_we, .acc_space, .acc_be, .acc_wdata, .acc_ack, .acc_rvalid, .acc_rdata,
    .mem_rdata, .space_select_n, .read_strobe_n, .write_strobe_n, .mem_wdata,
    .mem_wdata_oe);
  ebt_mem_model mem_u (.ref_clk, .space_select_n, .read_strobe_n, .write_strobe_n,
    .mem_wdata, .mem_rdata);

  // ------------------------------------------------------------
  // shared tasks and expectations
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // idle cycles owed between two accesses, from the earlier access's space
  function automatic int exp_gap(logic [15:0] c, logic pwr, logic [1:0] p, logic nw,
      logic [1:0] n);
    int iw, cw;
    iw = (!pwr && (p != n || nw)) ? c[8 + 2 * p +: 2] : 0;
    cw = (p == n) ? c[4 + p] : 0;
    return (iw > cw) ? iw : cw;
  endfunction : exp_gap

  // classic single cycle; request held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
      input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    check(n, 2);
    @(posedge ref_clk);
  endtask : wb

  task automatic cfg_rd(input logic [15:0] e);
    wb(1'b0, EBT_CFG_OFF, 4'hf, 32'h0, q);
    check(q, {16'h0, e});
  endtask : cfg_rd

  // request stays up across back-to-back accesses, so gaps are exact
  task automatic acc(input logic we, input logic [1:0] sp, input logic [1:0] be,
      input logic [15:0] d);
    int n;
    n = 0;
    acc_req <= 1'b1;
    acc_we <= we;
    acc_space <= sp;
    acc_be <= be;
    acc_wdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (acc_ack !== 1'b1);
    check(n < 60, 1);
  endtask : acc

  // ------------------------------------------------------------
  // pin monitor
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    stb_now = (read_strobe_n === 1'b0) || (write_strobe_n !== 2'h3);
    if (srst) begin
      quiet = 0;
      cont = 1'b0;
      {cur_sw, cur_we, pw, ps, cur_sp, cur_be} = '0;
      word_sh = '{default: 16'h0};
    end else begin
      if (stb_now) check($countones(~space_select_n), 1);
      if (space_select_n === EBT_SEL_IDLE) check(stb_now, 0);
      // an unstretched write strobes in its ack cycle, before cur_be is updated
      if (write_strobe_n !== 2'h3)
        check(write_strobe_n, (acc_ack === 1'b1) ? {~acc_be} : {~cur_be});
      if (stb_prev && !stb_now && cur_sw) begin
        check(space_select_n[cur_sp], 0);
        if (cur_we) check(mem_wdata_oe, 1);
      end
      if (acc_rvalid === 1'b1 && rq.size() > 0) check(acc_rdata, rq.pop_front());
      else if (acc_rvalid === 1'b1) check(acc_rvalid, 0);
      if (acc_ack === 1'b1) begin
        if (cont) check(quiet, exp_gap(cfg_sh, pw, ps, acc_we, acc_space));
        check(stb_now, !cfg_sh[acc_space]);
        check(space_select_n[acc_space], 0);
        pw = acc_we;
        ps = acc_space;
        cur_sp = acc_space;
        cur_we = acc_we;
        cur_be = acc_be;
        cur_sw = cfg_sh[acc_space];
        if (!acc_we) rq.push_back(word_sh[acc_space]);
        if (acc_we && acc_be[0]) word_sh[acc_space][7:0] = acc_wdata[7:0];
        if (acc_we && acc_be[1]) word_sh[acc_space][15:8] = acc_wdata[15:8];
        cont = 1'b1;
      end
      if (acc_req !== 1'b1) cont = 1'b0;
      quiet = (space_select_n === EBT_SEL_IDLE) ? quiet + 1 : 0;
    end
    stb_prev = stb_now;
  end

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
  initial begin
    {srst, clk_en} = 2'b11;
    {hw_standby, sw_standby, wb_cyc_i, wb_stb_i, wb_we_i, acc_req, acc_we} = 7'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, acc_space, acc_be, acc_wdata} = '0;
    cfg_sh = 16'hffff;
    void'($urandom(32'h6a95));
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    cfg_rd(16'hffff);
    // status after reset: idle counter saturated, no previous access
    wb(1'b0, EBT_STAT_OFF, 4'hf, 32'h0, q);
    check(q, 32'h60);
    wb(1'b1, 4'h8, 4'hf, 32'hffffffff, q);
    wb(1'b0, 4'h8, 4'hf, 32'h0, q);
    check(q, 0);
    wb(1'b1, EBT_CFG_OFF, 4'h3, 32'h1234, q);
    wb(1'b1, EBT_CFG_OFF, 4'h2, 32'hab00, q);
    cfg_rd(16'hab34);
    // a frozen block must not see hardware standby
    clk_en <= 1'b0;
    hw_standby <= 1'b1;
    repeat (3) @(posedge ref_clk);
    {clk_en, hw_standby} <= 2'b10;
    @(posedge ref_clk);
    cfg_rd(16'hab34);
    hw_standby <= 1'b1;
    @(posedge ref_clk);
    hw_standby <= 1'b0;
    @(posedge ref_clk);
    cfg_rd(16'hffff);
    // software standby holds back a pending request and keeps the config
    wb(1'b1, EBT_CFG_OFF, 4'h3, 32'h5a0f, q);
    cfg_sh = 16'h5a0f;
    sw_standby <= 1'b1;
    acc_req <= 1'b1;
    repeat (6) begin
      @(posedge ref_clk);
      check(space_select_n, EBT_SEL_IDLE);
    end
    sw_standby <= 1'b0;
    acc(1'b0, 2'h1, 2'h3, 16'h0);
    acc_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cfg_rd(16'h5a0f);
    // status: last access a read of space 1, idle counter saturated
    wb(1'b0, EBT_STAT_OFF, 4'hf, 32'h0, q);
    check(q, 32'h7a);
    // random access chains under corner and random settings
    for (int k = 0; k < 10; k++) begin
      v = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($urandom);
      wb(1'b1, EBT_CFG_OFF, 4'h3, {16'h0, v}, q);
      cfg_sh = v;
      for (int j = 0; j < 14; j++) begin
        acc(1'($urandom), 2'($urandom), 2'($urandom_range(1, 3)), 16'($urandom));
      end
      acc_req <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
    check(rq.size(), 0);
    final_report();
  end
endmodule : tb_top
